// ### inc/accx_pkg.sv
// Purpose: shared constants, types and helpers of the calibration correction stage
// Assumes: 24-bit conversion words, parallel register port from the serial front end
// Notes: gains are unsigned with unity at 2^23; offsets are two's complement
package accx_pkg;

	// register word offsets
	localparam logic [7:0] ADDR_CH4_LOW = 8'h0c;
	localparam logic [7:0] ADDR_CH5_LOW = 8'h0d;
	localparam logic [7:0] ADDR_SYS_OFF = 8'h0e;
	localparam logic [7:0] ADDR_SYS_GAIN = 8'h0f;
	localparam logic [7:0] ADDR_SELF_OFF = 8'h10;
	localparam logic [7:0] ADDR_SELF_GAIN = 8'h11;

	// reset values
	localparam logic [23:0] RST_CH4_LOW = 24'h000000;
	localparam logic [23:0] RST_CH5_LOW = 24'h000000;
	localparam logic [23:0] RST_SYS_OFF = 24'h000000;
	localparam logic [23:0] RST_SYS_GAIN = 24'h7fffff;
	localparam logic [23:0] RST_SELF_OFF = 24'h000000;
	localparam logic [23:0] RST_SELF_GAIN = 24'hbf851b;

	// gain binary point: unity gain is 2^23, full code is close to 2x
	localparam int GAIN_FRAC_BITS = 23;

	// channels that own a lower limit
	localparam logic [2:0] CHAN_FOUR = 3'h4;
	localparam logic [2:0] CHAN_FIVE = 3'h5;

	// which internal calibration result the engine delivers
	localparam logic [1:0] CAL_KIND_SYS_OFF = 2'h0;
	localparam logic [1:0] CAL_KIND_SYS_GAIN = 2'h1;
	localparam logic [1:0] CAL_KIND_SELF_OFF = 2'h2;
	localparam logic [1:0] CAL_KIND_SELF_GAIN = 2'h3;

	// one conversion word moving down the pipe
	typedef struct packed {
		logic valid;
		logic [2:0] chan;
		logic [23:0] data;
	} accx_sample_s;

	// control bits of the third control register
	typedef struct packed {
		logic cal_readback_select;
		logic sys_offset_bypass;
		logic sys_gain_bypass;
		logic self_offset_bypass;
		logic self_gain_bypass;
		logic unipolar;
	} accx_ctrl_s;

	// calibrations in progress
	typedef struct packed {
		logic self_cal;
		logic sys_off;
		logic sys_gain;
	} accx_busy_s;

	// result word handed over by the calibration engine
	typedef struct packed {
		logic valid;
		logic [1:0] kind;
		logic [23:0] value;
	} accx_calres_s;

	// clamp a wide signed value into the 24-bit two's complement range
	function automatic logic [23:0] accx_sat24(input logic signed [49:0] v);
		if (v > 50'sh7fffff) begin
			return 24'h7fffff;
		end else if (v < -50'sh800000) begin
			return 24'h800000;
		end
		return v[23:0];
	endfunction

endpackage

// ### rtl/accx_off_stage.sv
// Purpose: one offset subtraction step of the correction pipe
// Assumes: offset is two's complement, result saturates
// Notes: one cycle of latency whether bypassed or not
`timescale 1ns/1ps
module accx_off_stage
	import accx_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// data
	input accx_sample_s in_s,
	output accx_sample_s out_ff,
	// settings
	input wire logic [23:0] offset,
	input wire logic bypass
);

	logic signed [49:0] diff;

	// sign-extend both sides so the clamp sees the true difference
	assign diff = 50'(signed'(in_s.data)) - 50'(signed'(offset));

	// bypass keeps the latency so channel tags stay aligned
	always_ff @(posedge clock) begin
		if (rst) begin
			out_ff <= '0;
		end else begin
			out_ff.valid <= in_s.valid;
			out_ff.chan <= in_s.chan;
			out_ff.data <= bypass ? in_s.data : accx_sat24(diff);
		end
	end

endmodule

// ### rtl/accx_gain_stage.sv
// Purpose: one gain multiplication step of the correction pipe
// Assumes: gain unsigned, unity at 2^FRAC
// Notes: product is truncated toward minus infinity, then clamped
`timescale 1ns/1ps
module accx_gain_stage
	import accx_pkg::*;
#(
	parameter int FRAC = GAIN_FRAC_BITS
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// data
	input accx_sample_s in_s,
	output accx_sample_s out_ff,
	// settings
	input wire logic [23:0] gain,
	input wire logic bypass
);

	logic signed [49:0] prod;
	logic signed [49:0] scaled;

	// gain gets a zero sign bit so it is never read as negative
	assign prod = 50'(signed'(in_s.data)) * 50'(signed'({1'b0, gain}));
	assign scaled = prod >>> FRAC;

	// bypass keeps the latency so channel tags stay aligned
	always_ff @(posedge clock) begin
		if (rst) begin
			out_ff <= '0;
		end else begin
			out_ff.valid <= in_s.valid;
			out_ff.chan <= in_s.chan;
			out_ff.data <= bypass ? in_s.data : accx_sat24(scaled);
		end
	end

endmodule

// ### rtl/accx_cal_correct.sv
// Purpose: calibration correction stage with its calibration and lower-limit registers
// Assumes: a serial front end turns host transfers into single-cycle word strobes
// Notes: five-cycle pipe; user values steer the pipe, engine results are kept apart
//
// What this block does
// - keeps a 24-bit lower limit for channels 4 and 5 and flags results below it.
// - holds the system offset as a 24-bit two's complement word moved msb first.
// - a calibration read gives the user value when readback select is 1, else the engine.
// - the engine result read path is only valid while a conversion is running.
// - a system calibration keeps its result apart and leaves the user words alone.
// - with the system offset bypass at 0 the system offset is subtracted.
// - system offset comes after self corrections, before system gain and the scale.
// - host writes to the system offset are dropped during a system offset calibration.
// - holds the system gain as an unsigned 24-bit word moved msb first.
// - with the system gain bypass at 0 the result is multiplied by up to 2x.
// - host writes to the system gain are dropped during a system gain calibration.
// - with the self offset bypass at 0 the self offset is subtracted first of all.
// - the self offset is a two's complement word that self calibration never overwrites.
// - host writes to the self offset are dropped during a self calibration.
// - with the self gain bypass at 0 the self gain scales before the system steps.
`timescale 1ns/1ps
module accx_cal_correct
	import accx_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// register port from the serial front end
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_addr,
	input wire logic [23:0] reg_wdata,
	output logic [23:0] reg_rdata_ff,
	output logic reg_rvalid_ff,
	output logic reg_rok_ff,
	// control and status from the sequencer
	input accx_ctrl_s ctrl,
	input accx_busy_s busy,
	input wire logic conv_active,
	input accx_calres_s cal_res,
	// conversion words
	input accx_sample_s raw_s,
	output accx_sample_s result_ff,
	output logic below_limit_ff
);

	// user copies steer the pipe; engine copies are only ever read back
	logic [23:0] ch4_low_ff;
	logic [23:0] ch5_low_ff;
	logic [23:0] sys_off_ff;
	logic [23:0] sys_gain_ff;
	logic [23:0] self_off_ff;
	logic [23:0] self_gain_ff;
	logic [23:0] int_sys_off_ff;
	logic [23:0] int_sys_gain_ff;
	logic [23:0] int_self_off_ff;
	logic [23:0] int_self_gain_ff;
	// pipe taps, one per correction step
	accx_sample_s s1;
	accx_sample_s s2;
	accx_sample_s s3;
	accx_sample_s s4;
	logic signed [49:0] doubled;
	logic [23:0] nxt_data;
	logic nxt_below;
	logic [23:0] nxt_rdata;
	logic nxt_rok;

	// word offsets hold the user registers; writes while a matching calibration runs are lost
	// a dropped write leaves no trace, so the host must check busy before relying on it
	always_ff @(posedge clock) begin
		if (rst) begin
			ch4_low_ff <= RST_CH4_LOW;
			ch5_low_ff <= RST_CH5_LOW;
			sys_off_ff <= RST_SYS_OFF;
			sys_gain_ff <= RST_SYS_GAIN;
			self_off_ff <= RST_SELF_OFF;
			self_gain_ff <= RST_SELF_GAIN;
		end else if (reg_wr_en) begin
			unique case (reg_addr)
				ADDR_CH4_LOW: ch4_low_ff <= reg_wdata;
				ADDR_CH5_LOW: ch5_low_ff <= reg_wdata;
				ADDR_SYS_OFF: begin
					if (!busy.sys_off) begin
						sys_off_ff <= reg_wdata;
					end
				end
				ADDR_SYS_GAIN: begin
					if (!busy.sys_gain) begin
						sys_gain_ff <= reg_wdata;
					end
				end
				ADDR_SELF_OFF: begin
					if (!busy.self_cal) begin
						self_off_ff <= reg_wdata;
					end
				end
				ADDR_SELF_GAIN: begin
					if (!busy.self_cal) begin
						self_gain_ff <= reg_wdata;
					end
				end
				default: ; // unmapped writes are ignored
			endcase
		end
	end

	// engine results land in their own words, never in the user copies
	// no host path reaches these, so a write can never collide with a result
	always_ff @(posedge clock) begin
		if (rst) begin
			int_sys_off_ff <= RST_SYS_OFF;
			int_sys_gain_ff <= RST_SYS_GAIN;
			int_self_off_ff <= RST_SELF_OFF;
			int_self_gain_ff <= RST_SELF_GAIN;
		end else if (cal_res.valid) begin
			unique case (cal_res.kind)
				CAL_KIND_SYS_OFF: int_sys_off_ff <= cal_res.value;
				CAL_KIND_SYS_GAIN: int_sys_gain_ff <= cal_res.value;
				CAL_KIND_SELF_OFF: int_self_off_ff <= cal_res.value;
				CAL_KIND_SELF_GAIN: int_self_gain_ff <= cal_res.value;
			endcase
		end
	end

	// read mux; engine words only while converting, else zero with the ok flag low
	// a read and a write in the same cycle return the old word
	always_comb begin
		nxt_rdata = 24'h000000;
		nxt_rok = 1'b1;
		unique case (reg_addr)
			ADDR_CH4_LOW: nxt_rdata = ch4_low_ff;
			ADDR_CH5_LOW: nxt_rdata = ch5_low_ff;
			ADDR_SYS_OFF: nxt_rdata = ctrl.cal_readback_select ? sys_off_ff : int_sys_off_ff;
			ADDR_SYS_GAIN: nxt_rdata = ctrl.cal_readback_select ? sys_gain_ff : int_sys_gain_ff;
			ADDR_SELF_OFF: nxt_rdata = ctrl.cal_readback_select ? self_off_ff : int_self_off_ff;
			ADDR_SELF_GAIN: begin
				nxt_rdata = ctrl.cal_readback_select ? self_gain_ff : int_self_gain_ff;
			end
			default: nxt_rok = 1'b0;
		endcase
		if (reg_addr >= ADDR_SYS_OFF && reg_addr <= ADDR_SELF_GAIN && !ctrl.cal_readback_select
			&& !conv_active) begin
			nxt_rdata = 24'h000000;
			nxt_rok = 1'b0;
		end
	end

	// read answer one cycle after the strobe
	always_ff @(posedge clock) begin
		if (rst) begin
			reg_rdata_ff <= 24'h000000;
			reg_rvalid_ff <= 1'b0;
			reg_rok_ff <= 1'b0;
		end else begin
			reg_rvalid_ff <= reg_rd_en;
			if (reg_rd_en) begin
				reg_rdata_ff <= nxt_rdata;
				reg_rok_ff <= nxt_rok;
			end
		end
	end

	// each stage reads its settings live; a change mid-flight only hits later stages
	// self offset first of all
	accx_off_stage u_self_off (
		.clock(clock),
		.rst(rst),
		.in_s(raw_s),
		.out_ff(s1),
		.offset(self_off_ff),
		.bypass(ctrl.self_offset_bypass)
	);

	// self gain on the self-offset-corrected word
	accx_gain_stage #(.FRAC(GAIN_FRAC_BITS)) u_self_gain (
		.clock(clock),
		.rst(rst),
		.in_s(s1),
		.out_ff(s2),
		.gain(self_gain_ff),
		.bypass(ctrl.self_gain_bypass)
	);

	// system offset after both self steps
	accx_off_stage u_sys_off (
		.clock(clock),
		.rst(rst),
		.in_s(s2),
		.out_ff(s3),
		.offset(sys_off_ff),
		.bypass(ctrl.sys_offset_bypass)
	);

	// system gain on the offset-corrected word, up to 2x
	accx_gain_stage #(.FRAC(GAIN_FRAC_BITS)) u_sys_gain (
		.clock(clock),
		.rst(rst),
		.in_s(s3),
		.out_ff(s4),
		.gain(sys_gain_ff),
		.bypass(ctrl.sys_gain_bypass)
	);

	// unipolar doubles last, bipolar passes 1x; limit test uses the final word
	// doubling after the gains keeps the gain range the same in both polarities
	assign doubled = 50'(signed'(s4.data)) <<< 1;
	always_comb begin
		nxt_data = ctrl.unipolar ? accx_sat24(doubled) : s4.data;
		nxt_below = 1'b0;
		if (s4.valid && s4.chan == CHAN_FOUR) begin
			nxt_below = signed'(nxt_data) < signed'(ch4_low_ff);
		end else if (s4.valid && s4.chan == CHAN_FIVE) begin
			nxt_below = signed'(nxt_data) < signed'(ch5_low_ff);
		end
	end

	// the limit flag travels with its word so it is never paired with another sample
	// output register
	always_ff @(posedge clock) begin
		if (rst) begin
			result_ff <= '0;
			below_limit_ff <= 1'b0;
		end else begin
			result_ff.valid <= s4.valid;
			result_ff.chan <= s4.chan;
			result_ff.data <= nxt_data;
			below_limit_ff <= nxt_below;
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	// checks
	// register locks, then first read, data path, latency and limit checks
	sys_off_lock_a: assert property (busy.sys_off |=> $stable(sys_off_ff))
		else $error("system offset changed during its calibration");
	sys_gain_lock_a: assert property (busy.sys_gain |=> $stable(sys_gain_ff))
		else $error("system gain changed during its calibration");
	self_off_lock_a: assert property (busy.self_cal |=> $stable(self_off_ff))
		else $error("self offset changed during self calibration");
	user_kept_a: assert property (cal_res.valid && !reg_wr_en
		|=> $stable(sys_off_ff) && $stable(sys_gain_ff) && $stable(self_off_ff))
		else $error("engine result overwrote a user word");
	user_read_a: assert property (reg_rd_en && reg_addr == ADDR_SYS_OFF
		&& ctrl.cal_readback_select |=> reg_rvalid_ff && reg_rdata_ff == $past(sys_off_ff))
		else $error("user readback wrong");
	int_read_a: assert property (reg_rd_en && reg_addr == ADDR_SYS_GAIN
		&& !ctrl.cal_readback_select && !conv_active |=> !reg_rok_ff)
		else $error("engine readback marked valid outside conversion");
	sys_off_path_a: assert property (raw_s.valid && ctrl[4:0] == 5'b01110
		&& raw_s.data == 24'h001000 && sys_off_ff == 24'h000020
		##1 ($stable(ctrl) && $stable(sys_off_ff)) [*4] |=> result_ff.data == 24'h000fe0)
		else $error("system offset not subtracted");
	pipe_delay_a: assert property (raw_s.valid |-> ##5 result_ff.valid)
		else $error("pipe latency not five cycles");
	limit4_a: assert property (s4.valid && s4.chan == CHAN_FOUR && !ctrl.unipolar
		&& signed'(s4.data) < signed'(ch4_low_ff) |=> below_limit_ff)
		else $error("channel four low limit missed");
	gain_unity_a: assert property (s3.valid && !ctrl.sys_gain_bypass
		&& sys_gain_ff == 24'h800000 |=> s4.data == $past(s3.data))
		else $error("exact unity system gain altered the word");
	// read path, and host writes kept away from the engine words
	rd_pulse_a: assert property (!reg_rd_en |=> !reg_rvalid_ff)
		else $error("read answer without a read strobe");
	int_read_ok_a: assert property (reg_rd_en && reg_addr == ADDR_SELF_OFF
		&& !ctrl.cal_readback_select && conv_active
		|=> reg_rok_ff && reg_rdata_ff == $past(int_self_off_ff))
		else $error("engine readback wrong during conversion");
	int_kept_a: assert property (reg_wr_en && !cal_res.valid
		|=> $stable(int_sys_off_ff) && $stable(int_sys_gain_ff) && $stable(int_self_off_ff))
		else $error("host write reached an engine word");
	// data path
	self_off_path_a: assert property (raw_s.valid && ctrl[4:0] == 5'b11010
		&& raw_s.data == 24'h001000 && self_off_ff == 24'h000010
		##1 ($stable(ctrl) && $stable(self_off_ff)) [*4] |=> result_ff.data == 24'h000ff0)
		else $error("self offset not subtracted");
	self_gain_path_a: assert property (s1.valid && !ctrl.self_gain_bypass
		&& self_gain_ff == 24'h400000 && s1.data == 24'h001000 |=> s2.data == 24'h000800)
		else $error("self gain not applied");
	uni_scale_a: assert property (s4.valid && ctrl.unipolar
		&& s4.data == 24'h000fe0 |=> result_ff.data == 24'h001fc0)
		else $error("unipolar scale not applied last");
	uni_clamp_a: assert property (s4.valid && ctrl.unipolar
		&& s4.data == 24'h500000 |=> result_ff.data == 24'h7fffff)
		else $error("unipolar scale did not saturate");
	// limit compare
	limit5_a: assert property (s4.valid && s4.chan == CHAN_FIVE && !ctrl.unipolar
		&& signed'(s4.data) < signed'(ch5_low_ff) |=> below_limit_ff)
		else $error("channel five low limit missed");
	limit_other_a: assert property (!(s4.valid && s4.chan == CHAN_FOUR)
		&& !(s4.valid && s4.chan == CHAN_FIVE) |=> !below_limit_ff)
		else $error("low limit flag on a channel without a limit");

	cov_low_hit: cover property (below_limit_ff);
	cov_blocked_wr: cover property (reg_wr_en && reg_addr == ADDR_SYS_OFF && busy.sys_off);
	cov_int_read: cover property (reg_rd_en && !ctrl.cal_readback_select && conv_active);
	cov_unipolar: cover property (result_ff.valid && ctrl.unipolar);
	cov_full_chain: cover property (result_ff.valid && ctrl[4:1] == 4'b0000);

endmodule

// ### testbench/accx_seq_model.sv
// Purpose: sequencer stand-in that runs one calibration and hands over its result
// Assumes: one calibration at a time, started by a one-cycle command while idle
// Notes: result word is scrambled outside its valid cycle
`timescale 1ns/1ps
module accx_seq_model
	import accx_pkg::*;
#(
	parameter int CAL_LEN = 6
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// command from the bench
	input wire logic start,
	input wire logic [1:0] kind,
	input wire logic [23:0] value,
	// towards the correction stage
	output accx_busy_s busy,
	output accx_calres_s cal_res
);
	logic [7:0] cnt_ff;
	logic [1:0] kind_ff;
	logic [23:0] val_ff;
	logic run;

	// count the calibration down; a start while running is ignored
	always_ff @(posedge clock) begin
		if (rst) begin
			cnt_ff <= 8'h00;
		end else if (start && !run) begin
			cnt_ff <= 8'(CAL_LEN);
		end else if (run) begin
			cnt_ff <= cnt_ff - 8'h01;
		end
	end

	// remember what is calibrated and what it will report
	always_ff @(posedge clock) begin
		if (start && !run) begin
			kind_ff <= kind;
			val_ff <= value;
		end
	end

	// busy stands for the whole run, result arrives in its last cycle
	assign run = (cnt_ff != 8'h00);
	assign busy.self_cal = run && kind_ff[1];
	assign busy.sys_off = run && (kind_ff == CAL_KIND_SYS_OFF);
	assign busy.sys_gain = run && (kind_ff == CAL_KIND_SYS_GAIN);
	assign cal_res.valid = (cnt_ff == 8'h01);
	assign cal_res.kind = kind_ff;
	assign cal_res.value = (cnt_ff == 8'h01) ? val_ff : ~val_ff;
endmodule

// ### testbench/adc_calibration_correction_tb.sv
// Purpose: self-checking bench for the calibration correction stage
// Assumes: strobes are one-cycle pulses, reads answer one cycle later
// Notes: gains of 0x400000 halve exactly, so expected words need no rounding
`timescale 1ns/1ps
module adc_calibration_correction_tb;
	import accx_pkg::*;
	logic clock;
	logic rst;
	logic reg_wr_en;
	logic reg_rd_en;
	logic [7:0] reg_addr;
	logic [23:0] reg_wdata;
	logic [23:0] reg_rdata_ff;
	logic reg_rvalid_ff;
	logic reg_rok_ff;
	logic sel;
	logic [3:0] byp;
	logic uni;
	accx_ctrl_s ctrl;
	accx_busy_s busy;
	logic conv_active;
	accx_calres_s cal_res;
	accx_sample_s raw;
	accx_sample_s result_ff;
	logic below_limit_ff;
	logic start;
	logic [1:0] kind;
	logic [23:0] value;
	int num_errors = 0;
	int tests_run = 0;
	int cycles = 0;
	logic [23:0] rtab [6] = '{RST_CH4_LOW, RST_CH5_LOW, RST_SYS_OFF, RST_SYS_GAIN,
		RST_SELF_OFF, RST_SELF_GAIN};
	logic [23:0] wtab [6] = '{24'h000100, 24'hfff000, 24'h000020, 24'h400000,
		24'h000010, 24'h400000};
	logic [3:0] btab [6] = '{4'b1111, 4'b1101, 4'b1110, 4'b0111, 4'b1011, 4'b0000};
	logic [23:0] etab [6] = '{24'h001000, 24'h000ff0, 24'h000800, 24'h000fe0,
		24'h000800, 24'h0003ec};

	// bypass bits in order: system offset, system gain, self offset, self gain
	assign ctrl = {sel, byp, uni};

	accx_cal_correct u_dut (
		.clock(clock),
		.rst(rst),
		.reg_wr_en(reg_wr_en),
		.reg_rd_en(reg_rd_en),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_rdata_ff(reg_rdata_ff),
		.reg_rvalid_ff(reg_rvalid_ff),
		.reg_rok_ff(reg_rok_ff),
		.ctrl(ctrl),
		.busy(busy),
		.conv_active(conv_active),
		.cal_res(cal_res),
		.raw_s(raw),
		.result_ff(result_ff),
		.below_limit_ff(below_limit_ff)
	);

	accx_seq_model #(.CAL_LEN(6)) u_seq (
		.clock(clock),
		.rst(rst),
		.start(start),
		.kind(kind),
		.value(value),
		.busy(busy),
		.cal_res(cal_res)
	);

	// inputs always move one ns after the rising edge
	task automatic tick();
		@(posedge clock);
		#1;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t ns: seen %h, expected %h", $time, seen, exp);
		end
	endtask

	// whole 24-bit words; serial bit order is the front end's business
	task automatic wr(input logic [7:0] a, input logic [23:0] d);
		tick();
		reg_wr_en = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		tick();
		reg_wr_en = 1'b0;
		reg_wdata = ~d;
	endtask

	task automatic rd(input logic [7:0] a, input logic [23:0] exp, input logic ok);
		tick();
		reg_rd_en = 1'b1;
		reg_addr = a;
		tick();
		reg_rd_en = 1'b0;
		chk({6'h00, reg_rvalid_ff, reg_rok_ff, reg_rdata_ff}, {6'h00, 1'b1, ok, exp});
	endtask

	// one word in, then wait for it with a bounded count; latency must be five
	task automatic pipe(input logic [2:0] ch, input logic [23:0] d, input logic [23:0] exp,
		input logic lo);
		int n;
		tick();
		raw.valid = 1'b1;
		raw.chan = ch;
		raw.data = d;
		tick();
		raw.valid = 1'b0;
		raw.data = ~d;
		n = 1;
		while (result_ff.valid !== 1'b1 && n < 8) begin
			tick();
			n++;
		end
		chk(32'(n), 32'd5);
		chk({4'h0, below_limit_ff, result_ff.chan, result_ff.data}, {4'h0, lo, ch, exp});
	endtask

	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	// hang guard: the whole sequence needs well under a thousand cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			end_of_test();
		end
	end

	initial begin
		int n;
		rst = 1'b1;
		{reg_wr_en, reg_rd_en, reg_addr, reg_wdata} = '0;
		{sel, byp, uni, conv_active, start, kind, value} = '0;
		raw = '0;
		repeat (5) @(posedge clock);
		#1;
		rst = 1'b0;
		sel = 1'b1;
		byp = 4'b1111;
		for (int i = 0; i < 6; i++) begin
			rd(ADDR_CH4_LOW + 8'(i), rtab[i], 1'b1);
		end
		rd(8'h12, 24'h000000, 1'b0);
		for (int i = 0; i < 6; i++) begin
			wr(ADDR_CH4_LOW + 8'(i), wtab[i]);
			rd(ADDR_CH4_LOW + 8'(i), wtab[i], 1'b1);
		end
		// each correction alone, then all of them in their fixed order
		for (int i = 0; i < 6; i++) begin
			byp = btab[i];
			pipe(3'h3, 24'h001000, etab[i], 1'b0);
		end
		byp = 4'b1111;
		pipe(3'h4, 24'h0000f0, 24'h0000f0, 1'b1);
		pipe(3'h4, 24'h000100, 24'h000100, 1'b0);
		pipe(3'h3, 24'h0000f0, 24'h0000f0, 1'b0);
		pipe(3'h5, 24'hffe000, 24'hffe000, 1'b1);
		// unipolar doubling comes after the system offset
		uni = 1'b1;
		byp = 4'b0111;
		pipe(3'h3, 24'h001000, 24'h001fc0, 1'b0);
		byp = 4'b1111;
		pipe(3'h3, 24'h500000, 24'h7fffff, 1'b0);
		uni = 1'b0;
		// each calibration kind: host write during the run must be dropped
		for (int k = 0; k < 4; k++) begin
			tick();
			start = 1'b1;
			kind = 2'(k);
			value = 24'h0a0000 + 24'(k);
			tick();
			start = 1'b0;
			wr(ADDR_SYS_OFF + 8'(k), 24'h555555);
			n = 0;
			while (busy !== 3'b000 && n < 20) begin
				tick();
				n++;
			end
			chk(32'(n < 20), 32'd1);
			sel = 1'b1;
			rd(ADDR_SYS_OFF + 8'(k), wtab[k + 2], 1'b1);
			sel = 1'b0;
			conv_active = 1'b1;
			rd(ADDR_SYS_OFF + 8'(k), 24'h0a0000 + 24'(k), 1'b1);
			conv_active = 1'b0;
			rd(ADDR_SYS_OFF + 8'(k), 24'h000000, 1'b0);
		end
		// engine results must not have reached the pipe
		byp = 4'b0000;
		pipe(3'h3, 24'h001000, 24'h0003ec, 1'b0);
		// exact unity system gain passes positive and negative words untouched
		wr(ADDR_SYS_GAIN, 24'h800000);
		byp = 4'b1011;
		pipe(3'h3, 24'h001000, 24'h001000, 1'b0);
		pipe(3'h3, 24'hfff000, 24'hfff000, 1'b0);
		end_of_test();
	end
endmodule
